//--- pkg/dsc_params.svh
// Timing counts and display limits for the dual-slope sequencer
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// Last prescaler value of each decade-counter count (4 oscillator clocks per count)
`define DSC_PRESCALE 2'h3
// Signal accumulate length, counts (1000)
`define DSC_INT_COUNTS 12'h3e8
// Largest reference discharge length, counts (2000)
`define DSC_DE_MAX_COUNTS 12'h7d0
// Whole measurement cycle, counts (4000)
`define DSC_CYCLE_COUNTS 12'hfa0
// Cycle position that closes the discharge window (3000)
`define DSC_DE_END 12'hbb8
// Oscillator divide ratio for the backplane (800)
`define DSC_BP_DIV 10'h320
// Oscillator clocks per backplane half period (400)
`define DSC_BP_HALF 9'h190
// Largest displayable reading, counts (1999)
`define DSC_FULL_SCALE 12'h7cf

`endif

//--- pkg/dsc_pkg.sv
// Types for the dual-slope sequencer and LCD drive
package dsc_pkg;

  typedef enum logic [1:0] {
    AUTO_ZERO_PHASE = 2'b00,
    SIGNAL_ACCUMULATE_PHASE = 2'b01,
    REFERENCE_DISCHARGE_PHASE = 2'b10
  } phase_t;

  typedef struct packed {
    logic thousands;
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] units;
  } bcd_t;

  typedef struct packed {
    logic negative_sign_segment;
    logic thousands_one_segment;
    logic [6:0] hundreds;
    logic [6:0] tens;
    logic [6:0] units;
  } lcd_seg_t;

  typedef struct packed {
    logic input_short;
    logic input_connect;
    logic offset_loop_close;
    logic ref_charge;
    logic in_low_to_common;
    logic ref_connect_pos;
    logic ref_connect_neg;
  } switch_t;

  typedef struct packed {
    phase_t phase;
    logic [1:0] prescale;
    logic [11:0] cycle_cnt;
    bcd_t count;
    logic sign_neg;
    bcd_t disp;
    logic disp_neg;
    logic [8:0] bp_cnt;
    logic bp;
    logic [1:0] comp_sync;
    logic [1:0] test_sync;
    switch_t sw;
    lcd_seg_t seg;
  } state_t;

endpackage : dsc_pkg

//--- hdl/seg7_decode.sv
// Seven-segment decoder, output order {g,f,e,d,c,b,a}
`timescale 1ns/1ps
`default_nettype none

module seg7_decode (
  // Digit in
  input wire logic [3:0] digit_i,
  // Segments out
  output logic [6:0] seg_o
);

  always_comb begin
    unique case (digit_i)
      4'h0: seg_o = 7'h3f;
      4'h1: seg_o = 7'h06;
      4'h2: seg_o = 7'h5b;
      4'h3: seg_o = 7'h4f;
      4'h4: seg_o = 7'h66;
      4'h5: seg_o = 7'h6d;
      4'h6: seg_o = 7'h7d;
      4'h7: seg_o = 7'h07;
      4'h8: seg_o = 7'h7f;
      4'h9: seg_o = 7'h6f;
      default: seg_o = 7'h00;
    endcase
  end

endmodule : seg7_decode

`default_nettype wire

//--- hdl/dual_slope_sequencer_lcd_drive.sv
// Dual-slope conversion sequencer with static LCD drive
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"

module dual_slope_sequencer_lcd_drive (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Analog front end
  input wire logic comparator_i,
  input wire logic lamp_test_i,
  output dsc_pkg::switch_t switch_o,
  output dsc_pkg::phase_t phase_o,
  // LCD glass
  output logic lcd_backplane_o,
  output dsc_pkg::lcd_seg_t segment_o
);

  // ==========================================================
  // Helpers
  function automatic dsc_pkg::bcd_t bcd_inc(input dsc_pkg::bcd_t v);
    dsc_pkg::bcd_t r;
    r = v;
    if (v == {1'b1, 4'h9, 4'h9, 4'h9}) begin
      r = v;
    end else if (v.units != 4'h9) begin
      r.units = v.units + 4'h1;
    end else begin
      r.units = 4'h0;
      if (v.tens != 4'h9) begin
        r.tens = v.tens + 4'h1;
      end else begin
        r.tens = 4'h0;
        if (v.hundreds != 4'h9) begin
          r.hundreds = v.hundreds + 4'h1;
        end else begin
          r.hundreds = 4'h0;
          r.thousands = 1'b1;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  // ==========================================================
  // Digit decoders
  logic [6:0] units_seg;
  logic [6:0] tens_seg;
  logic [6:0] hundreds_seg;
  dsc_pkg::state_t s_reg;
  dsc_pkg::state_t s_next;

  seg7_decode u_units (
    .digit_i(s_reg.disp.units),
    .seg_o(units_seg)
  );
  seg7_decode u_tens (
    .digit_i(s_reg.disp.tens),
    .seg_o(tens_seg)
  );
  seg7_decode u_hundreds (
    .digit_i(s_reg.disp.hundreds),
    .seg_o(hundreds_seg)
  );

  // ==========================================================
  // Next state
  logic tick;
  logic comp_pos;
  logic crossed;
  dsc_pkg::lcd_seg_t on_pat;

  always_comb begin
    s_next = s_reg;
    s_next.comp_sync = {s_reg.comp_sync[0], comparator_i};
    s_next.test_sync = {s_reg.test_sync[0], lamp_test_i};
    comp_pos = s_reg.comp_sync[1];
    tick = (s_reg.prescale == `DSC_PRESCALE);
    crossed = (comp_pos == s_reg.sign_neg);
    s_next.prescale = s_reg.prescale + 2'h1;

    if (tick) begin
      if (s_reg.cycle_cnt == `DSC_CYCLE_COUNTS - 12'h001) begin
        s_next.cycle_cnt = 12'h000;
      end else begin
        s_next.cycle_cnt = s_reg.cycle_cnt + 12'h001;
      end
      unique case (s_reg.phase)
        dsc_pkg::AUTO_ZERO_PHASE: begin
          if (s_reg.cycle_cnt == `DSC_CYCLE_COUNTS - 12'h001) begin
            s_next.phase = dsc_pkg::SIGNAL_ACCUMULATE_PHASE;
          end
        end
        dsc_pkg::SIGNAL_ACCUMULATE_PHASE: begin
          if (s_reg.cycle_cnt == `DSC_INT_COUNTS - 12'h001) begin
            s_next.phase = dsc_pkg::REFERENCE_DISCHARGE_PHASE;
            s_next.sign_neg = ~comp_pos;
            s_next.count = '0;
          end
        end
        dsc_pkg::REFERENCE_DISCHARGE_PHASE: begin
          if (crossed || s_reg.cycle_cnt == `DSC_DE_END - 12'h001) begin
            s_next.phase = dsc_pkg::AUTO_ZERO_PHASE;
            s_next.disp = s_reg.count;
            s_next.disp_neg = s_reg.sign_neg;
          end else begin
            s_next.count = bcd_inc(s_reg.count);
          end
        end
        default: s_next.phase = dsc_pkg::AUTO_ZERO_PHASE;
      endcase
    end

    // Switch network
    s_next.sw.input_short = (s_next.phase != dsc_pkg::SIGNAL_ACCUMULATE_PHASE);
    s_next.sw.input_connect = (s_next.phase == dsc_pkg::SIGNAL_ACCUMULATE_PHASE);
    s_next.sw.offset_loop_close = (s_next.phase == dsc_pkg::AUTO_ZERO_PHASE);
    s_next.sw.ref_charge = (s_next.phase == dsc_pkg::AUTO_ZERO_PHASE);
    s_next.sw.in_low_to_common = (s_next.phase != dsc_pkg::SIGNAL_ACCUMULATE_PHASE);
    s_next.sw.ref_connect_pos = (s_next.phase == dsc_pkg::REFERENCE_DISCHARGE_PHASE)
                                && s_next.sign_neg;
    s_next.sw.ref_connect_neg = (s_next.phase == dsc_pkg::REFERENCE_DISCHARGE_PHASE)
                                && !s_next.sign_neg;

    // Backplane
    if (s_reg.bp_cnt == `DSC_BP_HALF - 9'h001) begin
      s_next.bp_cnt = 9'h000;
      s_next.bp = ~s_reg.bp;
    end else begin
      s_next.bp_cnt = s_reg.bp_cnt + 9'h001;
    end

    // Segment drive
    on_pat.negative_sign_segment = s_reg.disp_neg;
    on_pat.thousands_one_segment = s_reg.disp.thousands;
    on_pat.hundreds = hundreds_seg;
    on_pat.tens = tens_seg;
    on_pat.units = units_seg;
    if (s_reg.test_sync[1]) begin
      s_next.seg = '1;
    end else begin
      s_next.seg = on_pat ^ {$bits(dsc_pkg::lcd_seg_t){s_next.bp}};
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.phase <= dsc_pkg::AUTO_ZERO_PHASE;
      s_reg.cycle_cnt <= `DSC_DE_END;
      s_reg.sw.input_short <= 1'b1;
      s_reg.sw.offset_loop_close <= 1'b1;
      s_reg.sw.ref_charge <= 1'b1;
      s_reg.sw.in_low_to_common <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign switch_o = s_reg.sw;
  assign phase_o = s_reg.phase;
  assign lcd_backplane_o = s_reg.bp;
  assign segment_o = s_reg.seg;

endmodule : dual_slope_sequencer_lcd_drive

`default_nettype wire

//--- test/dsc_asserts.sv
// Port property checker for the dual-slope sequencer
`timescale 1ns/1ps
`default_nettype none
module dsc_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Analog front end
  input wire logic comparator_i,
  input wire logic lamp_test_i,
  input wire dsc_pkg::switch_t switch_o,
  input wire dsc_pkg::phase_t phase_o,
  // LCD glass
  input wire logic lcd_backplane_o,
  input wire dsc_pkg::lcd_seg_t segment_o
);
  localparam dsc_pkg::phase_t PZ = dsc_pkg::AUTO_ZERO_PHASE;
  localparam dsc_pkg::phase_t PI = dsc_pkg::SIGNAL_ACCUMULATE_PHASE;
  localparam dsc_pkg::phase_t PD = dsc_pkg::REFERENCE_DISCHARGE_PHASE;
  // ====
  // Run lengths of phases and backplane halves
  logic [13:0] run_reg;
  logic [13:0] de_reg;
  logic [9:0] bp_reg;
  logic arm_reg;
  logic bp_arm_reg;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_reg <= 14'h0;
      de_reg <= 14'h0;
      bp_reg <= 10'h0;
      arm_reg <= 1'b0;
      bp_arm_reg <= 1'b0;
    end else begin
      run_reg <= $changed(phase_o) ? 14'h1 : run_reg + 14'h1;
      bp_reg <= $changed(lcd_backplane_o) ? 10'h1 : bp_reg + 10'h1;
      bp_arm_reg <= bp_arm_reg | $changed(lcd_backplane_o);
      if (phase_o == PZ && $past(phase_o) == PD) begin
        de_reg <= run_reg;
        arm_reg <= 1'b1;
      end
    end
  end
  a_phase_order: assert property (
    $changed(phase_o) |-> phase_o == ($past(phase_o) == PD ? PZ : $past(phase_o) + 2'h1))
    else $error("phase order broken");
  a_int_length: assert property (
    phase_o == PD && $past(phase_o) == PI |-> run_reg == 4000) else $error("accumulate length");
  a_de_window: assert property (
    phase_o == PZ && $past(phase_o) == PD |-> run_reg <= 8000) else $error("discharge too long");
  a_cycle_total: assert property (
    arm_reg && phase_o == PI && $past(phase_o) == PZ |-> run_reg + de_reg == 12000)
    else $error("cycle length");
  a_az_switches: assert property (
    phase_o == PZ |-> switch_o == 7'h5c) else $error("auto-zero switches");
  a_int_switches: assert property (
    phase_o == PI |-> switch_o.input_connect && !switch_o.input_short
      && !switch_o.offset_loop_close) else $error("accumulate switches");
  a_de_switches: assert property (
    phase_o == PD |-> switch_o.in_low_to_common && !switch_o.input_connect
      && (switch_o.ref_connect_pos != switch_o.ref_connect_neg)) else $error("discharge switches");
  a_bp_half: assert property (
    bp_arm_reg && $changed(lcd_backplane_o) |-> bp_reg == 400) else $error("backplane period");
  a_lamp_all: assert property (
    lamp_test_i [*4] |=> &segment_o) else $error("lamp test segments");
  a_lamp_steady: assert property (
    lamp_test_i [*5] |=> $stable(segment_o)) else $error("lamp test toggles");
endmodule : dsc_asserts
`default_nettype wire

//--- test/front_end_model.sv
// Integrator and comparator stand-in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  // Clock and sequencer phase
  input wire logic clk_sys_i,
  input wire dsc_pkg::phase_t phase_i,
  // Input level from the bench
  input wire logic neg_i,
  input wire logic [11:0] level_i,
  // Comparator
  output logic comparator_o = 1'b0
);
  logic [13:0] ramp_reg = 14'h0;
  // Ramp back one count per four clocks, then cross zero
  always @(posedge clk_sys_i) begin
    ramp_reg <= (phase_i == dsc_pkg::REFERENCE_DISCHARGE_PHASE) ? ramp_reg + 14'h1 : 14'h0;
    comparator_o <= (phase_i == dsc_pkg::REFERENCE_DISCHARGE_PHASE
      && ramp_reg >= {level_i, 2'h0}) ? neg_i : ~neg_i;
  end
endmodule : front_end_model
`default_nettype wire

//--- test/dual_slope_sequencer_lcd_drive_test.sv
// Self-checking bench for the dual-slope sequencer and LCD drive
`timescale 1ns/1ps
`default_nettype none
bind dual_slope_sequencer_lcd_drive dsc_asserts i_dsc_asserts (.clk_sys_i, .rst_i,
  .comparator_i, .lamp_test_i, .switch_o, .phase_o, .lcd_backplane_o, .segment_o);
module dual_slope_sequencer_lcd_drive_test;
  typedef struct {logic ng; int lvl; int rd;} row_t;
  row_t rows[5] = '{'{0, 0, 0}, '{1, 345, 345}, '{0, 1000, 1000}, '{0, 1999, 1999},
    '{1, 2400, 1999}};
  logic clk_sys_i;
  logic rst_i;
  logic lamp_test_i;
  logic comparator_i;
  logic neg;
  logic [11:0] level;
  dsc_pkg::switch_t switch_o;
  dsc_pkg::phase_t phase_o;
  logic lcd_backplane_o;
  dsc_pkg::lcd_seg_t segment_o;
  dsc_pkg::lcd_seg_t v;
  dsc_pkg::lcd_seg_t e;
  int err_total;
  int cmp_count;
  dual_slope_sequencer_lcd_drive i_dual_slope_sequencer_lcd_drive (.clk_sys_i, .rst_i,
    .comparator_i, .lamp_test_i, .switch_o, .phase_o, .lcd_backplane_o, .segment_o);
  front_end_model i_front_end_model (.clk_sys_i, .phase_i(phase_o), .neg_i(neg),
    .level_i(level), .comparator_o(comparator_i));
  // ====
  // Helpers
  function automatic dsc_pkg::lcd_seg_t pat(logic ng, int n);
    logic [6:0] t [10];
    t = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    n = n < 0 ? 0 : (n > 1999 ? 1999 : n);
    return {ng, n > 999, t[n / 100 % 10], t[n / 10 % 10], t[n % 10]};
  endfunction : pat
  task automatic chk(string nm, logic [22:0] seen, logic [22:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic wph(dsc_pkg::phase_t p);
    int k;
    for (k = 0; k < 20000 && phase_o !== p; k++) cyc(1);
    if (k == 20000) begin
      err_total++;
      results();
    end
  endtask : wph
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // ====
  // Main sequence
  initial begin
    rst_i = 1'b1;
    lamp_test_i = 1'b0;
    neg = 1'b0;
    level = 12'h000;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_sys_i);
      neg <= rows[i].ng;
      level <= rows[i].lvl[11:0];
      wph(dsc_pkg::REFERENCE_DISCHARGE_PHASE);
      wph(dsc_pkg::AUTO_ZERO_PHASE);
      cyc(201);
      v = segment_o ^ {23{lcd_backplane_o}};
      e = pat(rows[i].ng, rows[i].rd);
      chk("reading", v, e);
    end
    @(posedge clk_sys_i);
    lamp_test_i <= 1'b1;
    cyc(10);
    chk("lamp", segment_o, '1);
    cyc(500);
    chk("lamp hold", segment_o, '1);
    @(posedge clk_sys_i);
    lamp_test_i <= 1'b0;
    rst_i <= 1'b1;
    cyc(4);
    chk("reset phase", {21'h0, phase_o}, 23'h0);
    chk("reset switches", {16'h0, switch_o}, 23'h5c);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    cyc(3);
    chk("reset display", segment_o ^ {23{lcd_backplane_o}}, pat(1'b0, 0));
    wph(dsc_pkg::SIGNAL_ACCUMULATE_PHASE);
    results();
  end
endmodule : dual_slope_sequencer_lcd_drive_test
`default_nettype wire
